// ==== src/fsq_cfg.svh ====
// Purpose: Constants for the flash command sequencer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Block ids and protection layout are local choices
`ifndef FSQ_CFG_SVH
`define FSQ_CFG_SVH
// ==========================================
// Register offsets
`define FSQ_OFS_STATUS 12'h000
`define FSQ_OFS_INDEX 12'h004
`define FSQ_OFS_PARAM 12'h008
`define FSQ_OFS_MODE 12'h00C
`define FSQ_OFS_PROT 12'h010
// ==========================================
// Status field positions
`define FSQ_BIT_DONE 7
`define FSQ_BIT_ACC 5
`define FSQ_BIT_PROT 4
`define FSQ_BIT_VERR 1
`define FSQ_BIT_UNC 0
`define FSQ_BIT_SEC 8
// ==========================================
// Command codes and launch indices
`define FSQ_CMD_OTP 8'h07
`define FSQ_CMD_ERALL 8'h08
`define FSQ_CMD_ERBLK 8'h09
`define FSQ_CMD_ERSEC 8'h0A
`define FSQ_CMD_UNSEC 8'h0B
`define FSQ_IDX_OTP 3'h5
`define FSQ_IDX_ALL 3'h0
`define FSQ_IDX_ERASE 3'h1
`define FSQ_OTP_MAX 16'h0007
// ==========================================
// Block ids (global address [22:16])
`define FSQ_PF_LO 7'h7C
`define FSQ_PF_HI 7'h7F
`define FSQ_PF_BLK0 7'h7F
`define FSQ_DF_BLK 7'h10
// ==========================================
// Reset values
`define FSQ_RST_MODE 5'h1F
`define FSQ_RST_PROT 5'h00
`endif

// ==== src/fsq_pkg.sv ====
// Purpose: Types for the flash command sequencer
// Assumes: Used with fsq_cfg.svh
// Notes: Nothing here is imported
package fsq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_BLANK = 5'h04,
    ST_OPER = 5'h08,
    ST_DONE = 5'h10
  } fsq_state_t;
  typedef enum logic [2:0] {
    OP_BLANK_OTP = 3'h0,
    OP_PROG_OTP = 3'h1,
    OP_ERASE_ALL = 3'h2,
    OP_ERASE_BLK = 3'h3,
    OP_ERASE_SEC = 3'h4
  } fsq_op_t;
  typedef struct packed {
    fsq_op_t op;
    logic [22:0] addr;
    logic [63:0] data;
  } fsq_arr_req_t;
  typedef struct packed {
    logic done;
    logic blank;
    logic verr;
    logic unc;
  } fsq_arr_rsp_t;
endpackage

// ==== src/fsq_flash_seq.sv ====
// Purpose: Command sequencer for one-time program, erase and unsecure
// Assumes: APB slave, zero wait states; array engine does each op and verify
// Notes: Array request is a level held until the engine reports done
`timescale 1ns/1ns
`include "fsq_cfg.svh"

// Summary of operation
// (R1) One-time program targets eight reserved phrases only
// (R2) One-time program needs code 0x07, index 101
// (R3) Blank check, program, verify; complete stays low
// (R4) Phrase index above 0x0007 gives access error
// (R5) Already programmed phrase gives access error
// (R6) Phrase programmed all ones stays programmable
// (R7) Block zero reads invalid during one-time program
// (R8) Verify errors set verify and uncorrectable flags
// (R9) Command barred in mode gives access error
// (R10) Code 0x08 erases all, releases security
// (R11) Erase-all and unsecure need launch index 000
// (R12) Any protection fails erase-all and unsecure
// (R13) Software writes nothing while those run
// (R14) Block erase: code 0x09, index 001
// (R15) Misaligned block erase address gives access error
// (R16) Invalid block id gives access error
// (R17) Protected block fails block erase
// (R18) Sector erase: code 0x0A, index 001
// (R19) Sector address bits [2:0] nonzero: error
// (R20) Protected sector fails sector erase
// (R21) Unsecure verify failure keeps security unchanged
// (R22) Clearing complete launches; hardware sets it again
// (R23) Failed launch checks skip array, complete promptly
module fsq_flash_seq (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fsq_pkg::fsq_arr_req_t arrReq,
  output logic arrValid,
  input wire fsq_pkg::fsq_arr_rsp_t arrRsp,
  output logic block0ReadInvalid,
  output logic secure
);

  // ==========================================
  // Bus decode
  logic wrEn;
  logic rdEn;
  logic hitStatus;
  logic hitIndex;
  logic hitParam;
  logic hitMode;
  logic hitProt;
  logic hitAny;

  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign hitStatus = paddr == `FSQ_OFS_STATUS;
  assign hitIndex = paddr == `FSQ_OFS_INDEX;
  assign hitParam = paddr == `FSQ_OFS_PARAM;
  assign hitMode = paddr == `FSQ_OFS_MODE;
  assign hitProt = paddr == `FSQ_OFS_PROT;
  assign hitAny = hitStatus | hitIndex | hitParam | hitMode | hitProt;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hitAny;

  // ==========================================
  // Registers
  fsq_pkg::fsq_state_t state_reg;
  fsq_pkg::fsq_state_t state_next;
  logic [2:0] index_reg;
  logic [15:0] param_reg [0:5];
  logic [4:0] mode_reg;
  logic [4:0] prot_reg;
  logic done_reg;
  logic acc_reg;
  logic pviol_reg;
  logic verr_reg;
  logic unc_reg;
  logic secure_reg;
  logic [2:0] launchIdx_reg;
  logic busy;
  logic launch;

  assign busy = ~done_reg;
  // Writes while busy are dropped, so a stray access cannot corrupt a command
  assign launch = wrEn & hitStatus & pwdata[`FSQ_BIT_DONE] & done_reg; // R22

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      index_reg <= 3'h0;
    end else if (wrEn & hitIndex & ~busy) begin
      index_reg <= pwdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 6; i++) begin
        param_reg[i] <= 16'h0000;
      end
    end else if (wrEn & hitParam & ~busy & (index_reg < 3'h6)) begin
      param_reg[index_reg] <= pwdata[15:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `FSQ_RST_MODE;
      prot_reg <= `FSQ_RST_PROT;
    end else if (wrEn & ~busy) begin
      if (hitMode) begin
        mode_reg <= pwdata[4:0];
      end
      if (hitProt) begin
        prot_reg <= pwdata[4:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      launchIdx_reg <= 3'h0;
    end else if (launch) begin
      launchIdx_reg <= index_reg;
    end
  end

  // ==========================================
  // Launch checks
  logic [7:0] cmd;
  logic [6:0] blkId;
  logic [22:0] gaddr;
  logic isPf;
  logic isDf;
  logic blkValid;
  logic blkProt;
  logic anyProt;
  logic modeOk;
  logic accFail;
  logic protFail;

  function automatic logic modeBit(input logic [7:0] c, input logic [4:0] m);
    case (c)
      `FSQ_CMD_OTP: modeBit = m[0];
      `FSQ_CMD_ERALL: modeBit = m[1];
      `FSQ_CMD_ERBLK: modeBit = m[2];
      `FSQ_CMD_ERSEC: modeBit = m[3];
      `FSQ_CMD_UNSEC: modeBit = m[4];
      default: modeBit = 1'b0;
    endcase
  endfunction

  assign cmd = param_reg[0][15:8];
  assign blkId = param_reg[0][6:0];
  assign gaddr = {blkId, param_reg[1]};
  assign isPf = (blkId >= `FSQ_PF_LO) && (blkId <= `FSQ_PF_HI);
  assign isDf = blkId == `FSQ_DF_BLK;
  assign blkValid = isPf | isDf; // R16
  assign blkProt = isDf ? prot_reg[4] : prot_reg[blkId[1:0]];
  assign anyProt = |prot_reg;
  assign modeOk = modeBit(cmd, mode_reg); // R9

  always_comb begin
    accFail = ~modeOk; // R9
    protFail = 1'b0;
    case (cmd)
      `FSQ_CMD_OTP: begin
        // R1 R4
        if (launchIdx_reg != `FSQ_IDX_OTP || param_reg[1] > `FSQ_OTP_MAX) begin
          accFail = 1'b1; // R2
        end
      end
      `FSQ_CMD_ERALL, `FSQ_CMD_UNSEC: begin
        if (launchIdx_reg != `FSQ_IDX_ALL) begin
          accFail = 1'b1; // R11
        end
        protFail = anyProt; // R12
      end
      `FSQ_CMD_ERBLK: begin
        if (launchIdx_reg != `FSQ_IDX_ERASE || !blkValid) begin
          accFail = 1'b1; // R14
        end
        if ((isPf && gaddr[2:0] != 3'h0) || (isDf && gaddr[0])) begin
          accFail = 1'b1; // R15
        end
        protFail = blkValid & blkProt; // R17
      end
      `FSQ_CMD_ERSEC: begin
        if (launchIdx_reg != `FSQ_IDX_ERASE || !isPf) begin
          accFail = 1'b1; // R16 R18
        end
        if (gaddr[2:0] != 3'h0) begin
          accFail = 1'b1; // R19
        end
        protFail = isPf & blkProt; // R20
      end
      default: accFail = 1'b1;
    endcase
  end

  // ==========================================
  // Sequencer
  logic isOtp;
  assign isOtp = cmd == `FSQ_CMD_OTP;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fsq_pkg::ST_IDLE: begin
        if (launch) begin
          state_next = fsq_pkg::ST_CHECK;
        end
      end
      fsq_pkg::ST_CHECK: begin
        if (accFail | protFail) begin
          state_next = fsq_pkg::ST_DONE; // R23
        end else if (isOtp) begin
          state_next = fsq_pkg::ST_BLANK; // R3
        end else begin
          state_next = fsq_pkg::ST_OPER;
        end
      end
      fsq_pkg::ST_BLANK: begin
        if (arrRsp.done) begin
          // All-ones phrase reads blank, so it may be written again
          state_next = arrRsp.blank ? fsq_pkg::ST_OPER : fsq_pkg::ST_DONE; // R5 R6
        end
      end
      fsq_pkg::ST_OPER: begin
        if (arrRsp.done) begin
          state_next = fsq_pkg::ST_DONE;
        end
      end
      fsq_pkg::ST_DONE: state_next = fsq_pkg::ST_IDLE;
      default: state_next = fsq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fsq_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================
  // Array request
  fsq_pkg::fsq_op_t opSel;

  always_comb begin
    case (cmd)
      `FSQ_CMD_ERBLK: opSel = fsq_pkg::OP_ERASE_BLK;
      `FSQ_CMD_ERSEC: opSel = fsq_pkg::OP_ERASE_SEC;
      `FSQ_CMD_OTP: opSel = fsq_pkg::OP_PROG_OTP;
      default: opSel = fsq_pkg::OP_ERASE_ALL;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arrReq <= '0;
    end else if (state_reg == fsq_pkg::ST_CHECK) begin
      arrReq.op <= isOtp ? fsq_pkg::OP_BLANK_OTP : opSel;
      arrReq.addr <= gaddr;
      arrReq.data <= {param_reg[5], param_reg[4], param_reg[3], param_reg[2]};
    end else if (state_reg == fsq_pkg::ST_BLANK && arrRsp.done) begin
      arrReq.op <= fsq_pkg::OP_PROG_OTP;
    end
  end

  // Held from blank check into program; the engine's one-cycle done keeps the two ops apart
  assign arrValid = (state_reg == fsq_pkg::ST_BLANK) | (state_reg == fsq_pkg::ST_OPER);
  assign block0ReadInvalid = isOtp & busy; // R7

  // ==========================================
  // Status flags, set wins over software clear
  logic clrAcc;
  logic clrPv;
  logic clrVe;
  logic clrUn;
  logic setAcc;
  logic setPv;
  logic opEnd;

  assign clrAcc = wrEn & hitStatus & ~busy & pwdata[`FSQ_BIT_ACC];
  assign clrPv = wrEn & hitStatus & ~busy & pwdata[`FSQ_BIT_PROT];
  assign clrVe = wrEn & hitStatus & ~busy & pwdata[`FSQ_BIT_VERR];
  assign clrUn = wrEn & hitStatus & ~busy & pwdata[`FSQ_BIT_UNC];
  assign setAcc = ((state_reg == fsq_pkg::ST_CHECK) & accFail)
    | ((state_reg == fsq_pkg::ST_BLANK) & arrRsp.done & ~arrRsp.blank); // R5
  assign setPv = (state_reg == fsq_pkg::ST_CHECK) & protFail;
  assign opEnd = (state_reg == fsq_pkg::ST_OPER) & arrRsp.done;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b1;
    end else if (launch) begin
      done_reg <= 1'b0; // R22
    end else if (state_reg == fsq_pkg::ST_DONE) begin
      done_reg <= 1'b1; // R3 R22
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= 1'b0;
      pviol_reg <= 1'b0;
    end else begin
      acc_reg <= setAcc | (acc_reg & ~clrAcc);
      pviol_reg <= setPv | (pviol_reg & ~clrPv);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      verr_reg <= 1'b0;
      unc_reg <= 1'b0;
    end else begin
      verr_reg <= (opEnd & arrRsp.verr) | (verr_reg & ~clrVe); // R8
      unc_reg <= (opEnd & arrRsp.unc) | (unc_reg & ~clrUn); // R8
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      secure_reg <= 1'b1;
    end else if (opEnd & ~arrRsp.verr
      & ((cmd == `FSQ_CMD_ERALL) | (cmd == `FSQ_CMD_UNSEC))) begin
      secure_reg <= 1'b0; // R10 R21
    end
  end

  assign secure = secure_reg;

  // ==========================================
  // Read data
  always_comb begin
    prdata = 32'h0000_0000;
    if (rdEn) begin
      if (hitStatus) begin
        prdata[`FSQ_BIT_DONE] = done_reg;
        prdata[`FSQ_BIT_ACC] = acc_reg;
        prdata[`FSQ_BIT_PROT] = pviol_reg;
        prdata[`FSQ_BIT_VERR] = verr_reg;
        prdata[`FSQ_BIT_UNC] = unc_reg;
        prdata[`FSQ_BIT_SEC] = secure_reg;
      end else if (hitIndex) begin
        prdata[2:0] = index_reg;
      end else if (hitParam && index_reg < 3'h6) begin
        prdata[15:0] = param_reg[index_reg];
      end else if (hitMode) begin
        prdata[4:0] = mode_reg;
      end else if (hitProt) begin
        prdata[4:0] = prot_reg;
      end
    end
  end

endmodule

// ==== test/fsq_seq_sva.sv ====
// Purpose: Port checker for the flash command sequencer
// Assumes: Zero wait state APB, engine done is a one-cycle pulse
// Notes: Bound from tb_top
`timescale 1ns/1ns
`include "fsq_cfg.svh"
module fsq_seq_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fsq_pkg::fsq_arr_req_t arrReq,
  input wire logic arrValid,
  input wire fsq_pkg::fsq_arr_rsp_t arrRsp,
  input wire logic block0ReadInvalid,
  input wire logic secure
);
  // ==========
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire mapped = paddr <= `FSQ_OFS_PROT && paddr[1:0] == 2'h0;
  wire otpOp = arrReq.op == fsq_pkg::OP_BLANK_OTP || arrReq.op == fsq_pkg::OP_PROG_OTP;
  wire blankDone = arrValid && arrReq.op == fsq_pkg::OP_BLANK_OTP && arrRsp.done;
  pready_a: assert property (pready) else $error("pready low");
  slv_err_a: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  rdata_idle_a: assert property (!acc |-> prdata == 32'h0) else $error("prdata not zero");
  otp_inv_a: assert property (arrValid && otpOp |-> block0ReadInvalid) else $error("reads valid");
  start_op_a: assert property ($rose(arrValid) |-> arrReq.op != fsq_pkg::OP_PROG_OTP) else $error("no blank");
  prog_next_a: assert property (blankDone && arrRsp.blank |=> arrValid && arrReq.op == fsq_pkg::OP_PROG_OTP)
    else $error("no program after blank");
  reprog_stop_a: assert property (blankDone && !arrRsp.blank |=> !arrValid) else $error("reprogrammed");
  hold_req_a: assert property (arrValid && !arrRsp.done |=> arrValid && $stable(arrReq)) else $error("req moved");
  phrase_rng_a: assert property ($rose(arrValid) && otpOp |-> arrReq.addr[15:0] <= 16'h0007)
    else $error("phrase out of range");
  sec_rise_a: assert property (!$rose(secure)) else $error("secure set again");
  sec_keep_a: assert property (arrRsp.done && arrRsp.verr |=> $stable(secure) [*2]) else $error("secure moved");
  cover property (arrValid && arrReq.op == fsq_pkg::OP_PROG_OTP && arrRsp.done);
  cover property ($fell(secure));
  cover property (arrValid && arrReq.op == fsq_pkg::OP_ERASE_SEC);
endmodule

// ==== test/tb_top.sv ====
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Bench stands in for the array engine
// Notes: Only status reads while a command runs
`timescale 1ns/1ns
`include "fsq_cfg.svh"
module tb_top;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, arrValid, b0Inv, secure;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic sErr, blankV, verrV, uncV, sawInv;
  fsq_pkg::fsq_arr_req_t arrReq, lastReq;
  fsq_pkg::fsq_arr_rsp_t rsp;
  int nMismatch, testsRun;
  int cyc = 0;
  fsq_flash_seq dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arrReq(arrReq), .arrValid(arrValid), .arrRsp(rsp), .block0ReadInvalid(b0Inv), .secure(secure));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========
  // Engine stand-in: one done pulse per op
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rsp <= '{arrValid && !rsp.done, blankV, verrV, uncV};
    if (arrValid) begin
      lastReq <= arrReq;
      sawInv <= sawInv | b0Inv;
    end
    if (cyc == 20000) begin
      nMismatch++;
      completeRun();
    end
  end
  // ==========
  // Shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    sErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [6:0] b, input logic [15:0] p, input logic [2:0] ix);
    logic [31:0] k;
    apb(1'b1, `FSQ_OFS_INDEX, 32'h0);
    apb(1'b1, `FSQ_OFS_PARAM, {16'h0, c, 1'b0, b});
    for (k = 1; k < 6; k++) begin
      apb(1'b1, `FSQ_OFS_INDEX, k);
      apb(1'b1, `FSQ_OFS_PARAM, k == 1 ? {16'h0, p} : 32'h1100 + k);
    end
    apb(1'b1, `FSQ_OFS_INDEX, {29'h0, ix});
    apb(1'b1, `FSQ_OFS_STATUS, 32'h80);
    k = 0;
    do begin
      apb(1'b0, `FSQ_OFS_STATUS, 32'h0);
      k++;
    end while (rd[7] !== 1'b1 && k < 40);
  endtask
  task automatic ecase(input logic [7:0] c, input logic [6:0] b, input logic [15:0] p, input logic [2:0] ix,
    input logic [4:0] pr, input logic [31:0] ex);
    apb(1'b1, `FSQ_OFS_PROT, {27'h0, pr});
    cmd(c, b, p, ix);
    chk(rd, ex);
    apb(1'b1, `FSQ_OFS_STATUS, 32'h33);
  endtask
  task automatic completeRun();
    $display("Checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic tReset();
    apb(1'b0, `FSQ_OFS_STATUS, 32'h0);
    chk(rd, 32'h180);
    apb(1'b0, `FSQ_OFS_MODE, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b0, `FSQ_OFS_PROT, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h040, 32'hFF);
    apb(1'b0, 12'h040, 32'h0);
    chk({sErr, rd}, 33'h100000000);
    $display("reset test done");
  endtask
  task automatic tOtp();
    sawInv <= 1'b0;
    ecase(8'h07, 7'h00, 16'h0003, 3'h5, 5'h00, 32'h180);
    chk(lastReq.op, fsq_pkg::OP_PROG_OTP);
    chk(lastReq.data, 64'h1105110411031102);
    chk(lastReq.addr[15:0], 16'h0003);
    chk({sawInv, b0Inv}, 2'h2);
    ecase(8'h07, 7'h00, 16'h0008, 3'h5, 5'h00, 32'h1A0);
    ecase(8'h07, 7'h00, 16'h0002, 3'h4, 5'h00, 32'h1A0);
    blankV <= 1'b0;
    ecase(8'h07, 7'h00, 16'h0002, 3'h5, 5'h00, 32'h1A0);
    blankV <= 1'b1;
    verrV <= 1'b1;
    ecase(8'h07, 7'h00, 16'h0007, 3'h5, 5'h00, 32'h182);
    chk(lastReq.addr[15:0], 16'h0007);
    verrV <= 1'b0;
    apb(1'b1, `FSQ_OFS_MODE, 32'h1E);
    ecase(8'h07, 7'h00, 16'h0001, 3'h5, 5'h00, 32'h1A0);
    apb(1'b1, `FSQ_OFS_MODE, 32'h1F);
    $display("one-time program test done");
  endtask
  task automatic tErase();
    ecase(8'h08, 7'h00, 16'h0000, 3'h0, 5'h01, 32'h190);
    ecase(8'h0B, 7'h00, 16'h0000, 3'h0, 5'h10, 32'h190);
    ecase(8'h0B, 7'h00, 16'h0000, 3'h1, 5'h00, 32'h1A0);
    ecase(8'h09, 7'h20, 16'h0000, 3'h1, 5'h00, 32'h1A0);
    ecase(8'h09, 7'h7E, 16'h0004, 3'h1, 5'h00, 32'h1A0);
    ecase(8'h09, 7'h7E, 16'h0000, 3'h1, 5'h04, 32'h190);
    ecase(8'h09, 7'h10, 16'h0002, 3'h1, 5'h00, 32'h180);
    chk(lastReq.op, fsq_pkg::OP_ERASE_BLK);
    chk(lastReq.addr, 23'h100002);
    ecase(8'h09, 7'h10, 16'h0001, 3'h1, 5'h00, 32'h1A0);
    ecase(8'h0A, 7'h10, 16'h0000, 3'h1, 5'h00, 32'h1A0);
    ecase(8'h05, 7'h00, 16'h0000, 3'h0, 5'h00, 32'h1A0);
    apb(1'b1, `FSQ_OFS_MODE, 32'h1B);
    ecase(8'h09, 7'h10, 16'h0002, 3'h1, 5'h00, 32'h1A0);
    apb(1'b1, `FSQ_OFS_MODE, 32'h1F);
    ecase(8'h0A, 7'h7D, 16'h0003, 3'h1, 5'h00, 32'h1A0);
    ecase(8'h0A, 7'h7D, 16'h0200, 3'h1, 5'h02, 32'h190);
    ecase(8'h0A, 7'h7C, 16'h0100, 3'h1, 5'h00, 32'h180);
    chk(lastReq.op, fsq_pkg::OP_ERASE_SEC);
    chk(lastReq.addr, 23'h7C0100);
    $display("erase test done");
  endtask
  task automatic tSecure();
    verrV <= 1'b1;
    uncV <= 1'b1;
    ecase(8'h0B, 7'h00, 16'h0000, 3'h0, 5'h00, 32'h183);
    verrV <= 1'b0;
    uncV <= 1'b0;
    ecase(8'h08, 7'h00, 16'h0000, 3'h0, 5'h00, 32'h080);
    chk(lastReq.op, fsq_pkg::OP_ERASE_ALL);
    ecase(8'h0B, 7'h00, 16'h0000, 3'h0, 5'h00, 32'h080);
    $display("security test done");
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rsp = '0;
    blankV = 1'b1;
    verrV = 1'b0;
    uncV = 1'b0;
    sawInv = 1'b0;
    nMismatch = 0;
    testsRun = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    tReset();
    tOtp();
    tErase();
    tSecure();
    completeRun();
  end
endmodule
bind fsq_flash_seq fsq_seq_sva chk_i (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .arrReq(arrReq), .arrValid(arrValid), .arrRsp(arrRsp), .block0ReadInvalid(block0ReadInvalid), .secure(secure));
